// File: nsl_top.sv
// Controlled-node state tracker with dual status/error LED sequencer.
`default_nettype none

module nsl_top
    import nsl_pkg::*;
#(
    parameter logic [TICK_W-1:0] TICK_CYCLES  = TICK_W'(nsl_pkg::TICK_CYC),
    parameter logic [MS_W-1:0]   WAIT_TIME_MS = MS_W'(nsl_pkg::WAIT_MS),
    parameter logic [MS_W-1:0]   FL_ON_MS     = MS_W'(nsl_pkg::FLASH_ON_MS),
    parameter logic [MS_W-1:0]   FL_OFF_MS    = MS_W'(nsl_pkg::FLASH_OFF_MS),
    parameter logic [MS_W-1:0]   FL_GROUP_MS  = MS_W'(nsl_pkg::GROUP_MS)
) (
    // Clock and reset.
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // Protocol events from the frame logic.
    input  wire logic              fb_traffic_i,
    input  wire logic              soc_i,
    input  wire logic              mgr_v2_i,
    input  wire logic              data_valid_i,
    input  wire logic              input_data_i,
    input  wire logic              cmd_valid_i,
    input  wire nsl_pkg::nsl_cmd_e cmd_i,
    // Error sources.
    input  wire logic              cfg_error_i,
    input  wire logic              hw_error_i,
    input  wire logic [3:0]        err_code_i,
    input  wire logic              cn_error_i,
    // Node number switches and allocation.
    input  wire logic [3:0]        node_sw_hi_i,
    input  wire logic [3:0]        node_sw_lo_i,
    input  wire logic              dna_mode_i,
    input  wire logic              dna_assigned_i,
    // State and data gating.
    output nsl_pkg::nsl_state_e    state_o,
    output logic                   comm_allow_o,
    output logic                   ip_allow_o,
    output logic                   pdo_active_o,
    output logic                   out_drive_o,
    output logic                   in_provide_o,
    output logic                   sys_stop_o,
    // Node number.
    output logic [7:0]             node_num_o,
    output logic                   node_valid_o,
    output logic                   node_invalid_o,
    // LED.
    output logic                   led_green_o,
    output logic                   led_red_o
);

    nsl_state_e      state_q;
    nsl_state_e      state_d;
    logic [TICK_W-1:0] pre_q;
    logic            tick_q;
    logic [MS_W-1:0] wait_q;
    logic [MS_W-1:0] bl_q;
    logic            bl_on_q;
    logic [MS_W-1:0] grp_q;
    logic [MS_W-1:0] slot_q;
    logic [1:0]      sidx_q;
    logic            stop_q;
    logic [7:0]      sw_meta_q;
    logic [7:0]      sw_q;
    logic            green_d;

    nsl_err_if eif ();

    // Millisecond tick shared by all timers.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= (pre_q == TICK_CYCLES - 1'b1) ? '0 : pre_q + 1'b1;
            tick_q <= (pre_q == TICK_CYCLES - 1'b1);
        end
    end

    // Command decode.
    wire cmd_stop   = cmd_valid_i && (cmd_i == NSL_CMD_STOP);
    wire cmd_ready  = cmd_valid_i && (cmd_i == NSL_CMD_READY);
    wire cmd_start  = cmd_valid_i && (cmd_i == NSL_CMD_START);
    wire cmd_preop2 = cmd_valid_i && (cmd_i == NSL_CMD_PREOP2);
    wire cmd_reset  = cmd_valid_i && (cmd_i == NSL_CMD_RESET);
    wire wait_done  = tick_q && (wait_q == WAIT_TIME_MS - 1'b1);
    wire stoppable  = (state_q == NSL_PRE_OP1) || (state_q == NSL_PRE_OP2)
                      || (state_q == NSL_READY)
                      || (state_q == NSL_OPERATIONAL);

    // Start-up wait in the not-active state.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= '0;
        end else if (state_q != NSL_NOT_ACTIVE) begin
            wait_q <= '0;
        end else if (tick_q && !wait_done) begin
            wait_q <= wait_q + 1'b1;
        end
    end

    // Operating state machine. A manager reset command restarts the wait unless the node is already not active.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            NSL_NOT_ACTIVE: begin
                if (fb_traffic_i) begin
                    state_d = NSL_PRE_OP1;
                end else if (wait_done) begin
                    state_d = NSL_BASIC_ETH;
                end
            end
            NSL_BASIC_ETH: begin
                if (fb_traffic_i) begin
                    state_d = NSL_PRE_OP1;
                end
            end
            NSL_PRE_OP1: begin
                if (!mgr_v2_i) begin
                    state_d = NSL_PRE_OP2;
                end else if (soc_i) begin
                    state_d = NSL_PRE_OP2;
                end
            end
            NSL_PRE_OP2: begin
                if (mgr_v2_i ? cmd_ready : data_valid_i) begin
                    state_d = NSL_READY;
                end
            end
            NSL_READY: begin
                if (!mgr_v2_i && input_data_i) begin
                    state_d = NSL_OPERATIONAL;
                end else if (mgr_v2_i && cmd_start) begin
                    state_d = NSL_OPERATIONAL;
                end
            end
            NSL_OPERATIONAL: begin
                state_d = NSL_OPERATIONAL;
            end
            NSL_STOPPED: begin
                if (cmd_preop2) begin
                    state_d = NSL_PRE_OP2;
                end
            end
            default: begin
                state_d = NSL_NOT_ACTIVE;
            end
        endcase
        if (stoppable && cmd_stop) begin
            state_d = NSL_STOPPED;
        end
        if (cmd_reset) begin
            state_d = NSL_NOT_ACTIVE;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= NSL_NOT_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // Flicker and blink timer; half period follows the state.
    wire [MS_W-1:0] half_ms = (state_q == NSL_STOPPED)
                              ? MS_W'(BLINK_MS) : MS_W'(FLICKER_MS);
    wire bl_end = tick_q && (bl_q >= half_ms - 1'b1);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bl_q    <= '0;
            bl_on_q <= 1'b0;
        end else if (bl_end) begin
            bl_q    <= '0;
            bl_on_q <= !bl_on_q;
        end else if (tick_q) begin
            bl_q    <= bl_q + 1'b1;
        end
    end

    // Flash groups repeating once per group period.
    wire grp_end  = tick_q && (grp_q == FL_GROUP_MS - 1'b1);
    wire slot_end = tick_q && (slot_q == FL_ON_MS + FL_OFF_MS - 1'b1);
    wire [1:0] nflash = (state_q == NSL_PRE_OP1) ? 2'h1 :
                        (state_q == NSL_PRE_OP2) ? 2'h2 :
                        (state_q == NSL_READY)   ? 2'h3 : 2'h0;
    wire flash_on = (sidx_q < nflash) && (slot_q < FL_ON_MS);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            grp_q  <= '0;
            slot_q <= '0;
            sidx_q <= '0;
        end else if (grp_end) begin
            grp_q  <= '0;
            slot_q <= '0;
            sidx_q <= '0;
        end else if (tick_q) begin
            grp_q  <= grp_q + 1'b1;
            slot_q <= slot_end ? '0 : slot_q + 1'b1;
            sidx_q <= (slot_end && sidx_q != 2'h3) ? sidx_q + 1'b1 : sidx_q;
        end
    end

    // Green pattern; it is driven independently of red so it overlays it.
    always_comb begin
        unique case (state_q)
            NSL_NOT_ACTIVE:  green_d = 1'b0;
            NSL_BASIC_ETH:   green_d = bl_on_q;
            NSL_PRE_OP1:     green_d = flash_on;
            NSL_PRE_OP2:     green_d = flash_on;
            NSL_READY:       green_d = flash_on;
            NSL_OPERATIONAL: green_d = 1'b1;
            NSL_STOPPED:     green_d = bl_on_q;
            default:         green_d = 1'b0;
        endcase
    end

    // System stop is held until the next restart.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stop_q <= 1'b0;
        end else if (cfg_error_i || hw_error_i) begin
            stop_q <= 1'b1;
        end
    end

    assign eif.tick   = tick_q;
    assign eif.active = stop_q;
    assign eif.code   = err_code_i;

    nsl_err_code u_err (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .e      (eif.gen)
    );

    // Switch pins cross into the clock domain through two flip-flops.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_meta_q <= '0;
            sw_q      <= '0;
        end else begin
            sw_meta_q <= {node_sw_hi_i, node_sw_lo_i};
            sw_q      <= sw_meta_q;
        end
    end

    wire sw_zero  = (sw_q == NODE_ZERO);
    wire sw_node  = !sw_zero && (sw_q <= NODE_MAX);
    wire sw_bad   = (sw_q > NODE_MAX) || (sw_zero && !dna_mode_i);
    wire red_solid = cn_error_i || (sw_zero && !dna_assigned_i);
    wire red_d    = stop_q ? eif.red : red_solid;

    // Registered outputs.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            comm_allow_o   <= 1'b0;
            ip_allow_o     <= 1'b0;
            pdo_active_o   <= 1'b0;
            out_drive_o    <= 1'b0;
            in_provide_o   <= 1'b0;
            sys_stop_o     <= 1'b0;
            node_num_o     <= '0;
            node_valid_o   <= 1'b0;
            node_invalid_o <= 1'b0;
            led_green_o    <= 1'b0;
            led_red_o      <= 1'b0;
        end else begin
            comm_allow_o   <= (state_q != NSL_NOT_ACTIVE);
            ip_allow_o     <= (state_q == NSL_BASIC_ETH);
            pdo_active_o   <= (state_q == NSL_OPERATIONAL);
            out_drive_o    <= (state_q == NSL_OPERATIONAL);
            in_provide_o   <= (state_q == NSL_OPERATIONAL);
            sys_stop_o     <= stop_q;
            node_num_o     <= sw_node ? sw_q : 8'h00;
            node_valid_o   <= sw_node || (sw_zero && dna_mode_i);
            node_invalid_o <= sw_bad;
            led_green_o    <= green_d;
            led_red_o      <= red_d;
        end
    end

    assign state_o = state_q;

    chk_na_green_dark: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_NOT_ACTIVE && $past(state_q) == NSL_NOT_ACTIVE)
            |-> !led_green_o)
        else $error("Green lit while not active.");

    chk_na_no_comm: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_NOT_ACTIVE) |=> !comm_allow_o)
        else $error("Communication allowed while not active.");

    chk_wait_to_basic: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_NOT_ACTIVE && wait_done && !fb_traffic_i
            && !cmd_reset) |=> (state_q == NSL_BASIC_ETH))
        else $error("Wait expiry did not reach basic Ethernet.");

    chk_traffic_pre1: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_NOT_ACTIVE && fb_traffic_i && !cmd_reset)
            |=> (state_q == NSL_PRE_OP1))
        else $error("Traffic did not move to pre-operational-1.");

    chk_v1_pre1_skip: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_PRE_OP1 && !mgr_v2_i && !cmd_valid_i)
            |=> (state_q == NSL_PRE_OP2))
        else $error("Version-1 pre-operational-1 did not advance.");

    chk_stop_by_cmd: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $changed(state_q == NSL_STOPPED) |->
            $past(cmd_valid_i && (cmd_i == NSL_CMD_STOP
                || cmd_i == NSL_CMD_PREOP2 || cmd_i == NSL_CMD_RESET)))
        else $error("Stopped state changed without a command.");

    chk_oper_green_on: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_OPERATIONAL)[*2] |-> led_green_o)
        else $error("Green not steady in operational.");

    chk_stop_no_data: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == NSL_STOPPED) |=> (!out_drive_o && !in_provide_o))
        else $error("Data exchanged while stopped.");

    chk_node_reserved: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (sw_q > NODE_MAX) |=> (node_invalid_o && !node_valid_o))
        else $error("Reserved switch value not flagged invalid.");

endmodule

`default_nettype wire

// File: nsl_pkg.sv
// Constants, state and command codes for the node state LED sequencer.
//
// Contract
// - Restart waits five seconds, green dark.
// - Not-active state refuses all communication.
// - No traffic in wait: basic Ethernet, flicker.
// - Traffic during wait: pre-operational-1 at once.
// - Basic Ethernet allows IP; traffic: pre-operational-1.
// - Version-1 manager: pre-op-1 to pre-op-2 immediately.
// - Version-2 manager: pre-op-2 after start-of-cycle.
// - Ready by command or data-valid flag.
// - Version-1: ready to operational on input data.
// - Operational: green steady, mapping and data active.
// - Stopped: no data either way, 2.5 Hz.
// - Stopped entered or left only by command.
// - One, two, three green flashes at 1 Hz.
// - Bad configuration or hardware: red system stop.
// - Four red phases, 150 or 600 ms.
// - Error code repeats every two seconds; with three or four long phases it restarts after the last phase.
// - Node number byte from two hex switches.
// - Switch zero valid only with dynamic allocation.
// - Switch 01 to EF is node number.
// - Switch F0 to FF is invalid.
// - Green pattern overlays the red indication.
// - Red lit: switch zero, no number assigned.
`default_nettype none

package nsl_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_NS       = 1000000;
    localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W        = 16;
    localparam int unsigned MS_W          = 13;

    // Durations in milliseconds, with the flicker and blink rates and the error phase count.
    localparam int unsigned WAIT_MS       = 5000;
    localparam int unsigned FLICKER_HZ    = 10;
    localparam int unsigned BLINK_HZ_X10  = 25;
    localparam int unsigned FLICKER_MS    = 1000 / (2 * FLICKER_HZ);
    localparam int unsigned BLINK_MS      = 10000 / (2 * BLINK_HZ_X10);
    localparam int unsigned GROUP_MS      = 1000;
    localparam int unsigned FLASH_ON_MS   = 150;
    localparam int unsigned FLASH_OFF_MS  = 150;
    localparam int unsigned ERR_SHORT_MS  = 150;
    localparam int unsigned ERR_LONG_MS   = 600;
    localparam int unsigned ERR_GAP_MS    = 150;
    localparam int unsigned ERR_PERIOD_MS = 2000;
    localparam int unsigned ERR_PHASES    = 4;

    // Node switch decode limits.
    localparam logic [7:0] NODE_ZERO     = 8'h00;
    localparam logic [7:0] NODE_MAX      = 8'hef;

    typedef enum logic [2:0] {
        NSL_NOT_ACTIVE  = 3'h0,
        NSL_PRE_OP1     = 3'h1,
        NSL_PRE_OP2     = 3'h3,
        NSL_READY       = 3'h2,
        NSL_OPERATIONAL = 3'h6,
        NSL_STOPPED     = 3'h7,
        NSL_BASIC_ETH   = 3'h4
    } nsl_state_e;

    typedef enum logic [2:0] {
        NSL_CMD_READY   = 3'h1,
        NSL_CMD_START   = 3'h2,
        NSL_CMD_STOP    = 3'h3,
        NSL_CMD_PREOP2  = 3'h4,
        NSL_CMD_RESET   = 3'h5
    } nsl_cmd_e;

endpackage

`default_nettype wire

// File: nsl_err_if.sv
// Link between the sequencer and its system-stop code generator.
`default_nettype none

interface nsl_err_if;
    logic       tick;
    logic       active;
    logic [3:0] code;
    logic       red;

    modport seq (output tick, output active, output code, input red);
    modport gen (input tick, input active, input code, output red);
endinterface

`default_nettype wire

// File: nsl_err_code.sv
// Red pulse-train generator for system-stop error codes.
`default_nettype none

module nsl_err_code
    import nsl_pkg::*;
(
    // Clock and reset.
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Sequencer side.
    nsl_err_if.gen    e
);

    logic [MS_W-1:0] frame_q;
    logic [MS_W-1:0] pc_q;
    logic [2:0]      ph_q;
    logic            on_q;
    logic [MS_W-1:0] len_q;

    // A set code bit selects the long phase; bit 0 is sent first.
    wire [MS_W-1:0] dur = e.code[ph_q[1:0]] ? MS_W'(ERR_LONG_MS)
                                             : MS_W'(ERR_SHORT_MS);
    wire on_end  = on_q && (pc_q == dur - 1'b1);
    wire gap_end = !on_q && (ph_q < 3'(ERR_PHASES - 1))
                   && (pc_q == MS_W'(ERR_GAP_MS - 1));
    wire done    = !on_q && (ph_q == 3'(ERR_PHASES - 1));
    // Restart at the period, or after the last phase when it runs over.
    wire wrap    = done && (frame_q >= MS_W'(ERR_PERIOD_MS - 1));

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_q <= '0;
            pc_q    <= '0;
            ph_q    <= '0;
            on_q    <= 1'b0;
        end else if (!e.active) begin
            frame_q <= '0;
            pc_q    <= '0;
            ph_q    <= '0;
            on_q    <= 1'b1;
        end else if (e.tick) begin
            frame_q <= wrap ? '0 : frame_q + 1'b1;
            pc_q    <= (on_end || gap_end || wrap) ? '0 : pc_q + 1'b1;
            ph_q    <= wrap ? '0 : (gap_end ? ph_q + 1'b1 : ph_q);
            on_q    <= wrap || gap_end || (on_q && !on_end);
        end
    end

    assign e.red = on_q && e.active;

    // Helper: length of the current red phase in milliseconds.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            len_q <= '0;
        end else if (!e.red) begin
            len_q <= '0;
        end else if (e.tick) begin
            len_q <= len_q + 1'b1;
        end
    end

    chk_err_phase_len: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ($fell(e.red) && e.active) |->
            (len_q == MS_W'(ERR_SHORT_MS) || len_q == MS_W'(ERR_LONG_MS)))
        else $error("Red error phase has a wrong length.");

endmodule

`default_nettype wire

// File: nsl_mgr_model.sv
// Behavioural model of the managing node that sends frames and commands.
`default_nettype none

module nsl_mgr_model
    import nsl_pkg::*;
(
    // Clock.
    input  wire logic             mclk_i,
    // Frames, flags and commands towards the node.
    output var logic              fb_traffic_o,
    output var logic              soc_o,
    output var logic              mgr_v2_o,
    output var logic              data_valid_o,
    output var logic              input_data_o,
    output var logic              cmd_valid_o,
    output var nsl_pkg::nsl_cmd_e cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        fb_traffic_o = 1'b0;
        soc_o        = 1'b0;
        mgr_v2_o     = 1'b0;
        data_valid_o = 1'b0;
        input_data_o = 1'b0;
        cmd_valid_o  = 1'b0;
        cmd_o        = NSL_CMD_READY;
    end

    task automatic set_mode(input logic v2, input logic dv, input logic ind);
        @(posedge mclk_i);
        mgr_v2_o     <= v2;
        data_valid_o <= dv;
        input_data_o <= ind;
    endtask

    // A start-of-cycle frame also counts as fieldbus traffic.
    task automatic send_frame(input logic soc);
        @(posedge mclk_i);
        fb_traffic_o <= 1'b1;
        soc_o        <= soc;
        @(posedge mclk_i);
        fb_traffic_o <= 1'b0;
        soc_o        <= 1'b0;
    endtask

    // The code lines toggle once the strobe drops, so stale codes never pass.
    task automatic send_cmd(input nsl_cmd_e c);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_o       <= nsl_cmd_e'(~c);
    endtask
endmodule

`default_nettype wire

// File: nsl_top_tb.sv
// Self-checking testbench of the node state LED sequencer.
`default_nettype none

module nsl_top_tb;
    import nsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TCK = 4;
    logic mclk_i = 1'b0;
    logic rst_i, cfg_error_i, hw_error_i, cn_error_i, dna_mode_i;
    logic dna_assigned_i;
    logic [3:0] err_code_i, node_sw_hi_i, node_sw_lo_i;
    logic fb, soc, v2, dv, ind, cv, comm, ip, pdo, od, ip_o, stop;
    logic nvalid, ninvalid, green, red;
    logic [7:0] num;
    nsl_cmd_e cmd;
    nsl_state_e state;
    int fails = 0;
    int checks = 0;

    always #10 mclk_i = ~mclk_i;

    nsl_mgr_model mgr_u (.mclk_i(mclk_i), .fb_traffic_o(fb), .soc_o(soc),
        .mgr_v2_o(v2), .data_valid_o(dv), .input_data_o(ind),
        .cmd_valid_o(cv), .cmd_o(cmd));

    nsl_top #(.TICK_CYCLES(16'(TCK)), .WAIT_TIME_MS(13'h00a),
        .FL_ON_MS(13'h002), .FL_OFF_MS(13'h002), .FL_GROUP_MS(13'h014))
    dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .fb_traffic_i(fb), .soc_i(soc),
        .mgr_v2_i(v2), .data_valid_i(dv), .input_data_i(ind),
        .cmd_valid_i(cv), .cmd_i(cmd), .cfg_error_i(cfg_error_i),
        .hw_error_i(hw_error_i), .err_code_i(err_code_i),
        .cn_error_i(cn_error_i), .node_sw_hi_i(node_sw_hi_i),
        .node_sw_lo_i(node_sw_lo_i), .dna_mode_i(dna_mode_i),
        .dna_assigned_i(dna_assigned_i), .state_o(state),
        .comm_allow_o(comm), .ip_allow_o(ip), .pdo_active_o(pdo),
        .out_drive_o(od), .in_provide_o(ip_o), .sys_stop_o(stop),
        .node_num_o(num), .node_valid_o(nvalid),
        .node_invalid_o(ninvalid), .led_green_o(green), .led_red_o(red));

    task automatic complete_run;
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_state(input nsl_state_e exp);
        checks++;
        if (state !== exp) begin
            fails++;
            $display("mismatch %0t state %0h want %0h", $time, state, exp);
        end
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t value %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic check_num(input int got, input int exp, input int tol);
        checks++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("mismatch %0t count %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic do_reset;
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask

    // Counts green rising edges over a window of len cycles.
    task automatic green_rises(input int len, output int n);
        logic p;
        n = 0;
        @(negedge mclk_i);
        p = green;
        repeat (len) begin
            @(negedge mclk_i);
            if (p === 1'b0 && green === 1'b1)
                n++;
            p = green;
        end
    endtask

    task automatic flash_count(input int exp);
        int n;
        ticks(8);
        green_rises(20 * TCK, n);
        check_num(n, exp, 0);
    endtask

    // Waits while red differs from lvl; k returns the cycles waited.
    task automatic wait_red(input logic lvl, input int bound, output int k);
        k = 0;
        do begin
            @(negedge mclk_i);
            k++;
        end while (red !== lvl && k < bound);
        if (k >= bound) begin
            fails++;
            $display("mismatch %0t red wait expired", $time);
            complete_run();
        end
    endtask

    task automatic wait_state(input nsl_state_e s, input int bound);
        int k;
        for (k = 0; k < bound && state !== s; k++)
            @(negedge mclk_i);
        if (k >= bound) begin
            fails++;
            $display("mismatch %0t state wait expired", $time);
            complete_run();
        end
    endtask

    task automatic set_sw(input logic [7:0] v, input logic dm, input logic da);
        @(posedge mclk_i);
        node_sw_hi_i   <= v[7:4];
        node_sw_lo_i   <= v[3:0];
        dna_mode_i     <= dm;
        dna_assigned_i <= da;
        ticks(6);
    endtask

    task automatic scen_wait_basic;
        int n;
        do_reset();
        ticks(30);
        check_state(NSL_NOT_ACTIVE);
        check_val(8'(comm), 8'h00);
        check_val(8'(green), 8'h00);
        wait_state(NSL_BASIC_ETH, 200);
        ticks(2);
        check_val(8'(ip), 8'h01);
        green_rises(800, n);
        check_num(n, 800 / (2 * FLICKER_MS * TCK), 0);
        mgr_u.send_frame(1'b0);
        ticks(1);
        check_state(NSL_PRE_OP1);
    endtask

    task automatic scen_v1_path;
        int n;
        do_reset();
        mgr_u.set_mode(1'b0, 1'b0, 1'b0);
        mgr_u.send_frame(1'b0);
        ticks(1);
        check_state(NSL_PRE_OP1);
        ticks(1);
        check_state(NSL_PRE_OP2);
        mgr_u.set_mode(1'b0, 1'b1, 1'b0);
        ticks(2);
        check_state(NSL_READY);
        mgr_u.set_mode(1'b0, 1'b1, 1'b1);
        ticks(2);
        check_state(NSL_OPERATIONAL);
        ticks(2);
        check_val({5'h00, pdo, od, ip_o}, 8'h07);
        green_rises(400, n);
        check_num(n, 0, 0);
        check_val(8'(green), 8'h01);
    endtask

    task automatic scen_v2_path;
        int n;
        do_reset();
        mgr_u.set_mode(1'b1, 1'b1, 1'b1);
        mgr_u.send_frame(1'b0);
        ticks(20);
        check_state(NSL_PRE_OP1);
        flash_count(1);
        mgr_u.send_frame(1'b1);
        ticks(1);
        check_state(NSL_PRE_OP2);
        flash_count(2);
        mgr_u.send_cmd(NSL_CMD_START);
        ticks(1);
        check_state(NSL_PRE_OP2);
        mgr_u.send_cmd(NSL_CMD_READY);
        ticks(1);
        check_state(NSL_READY);
        flash_count(3);
        check_state(NSL_READY);
        mgr_u.send_cmd(NSL_CMD_START);
        ticks(1);
        check_state(NSL_OPERATIONAL);
        mgr_u.send_cmd(NSL_CMD_STOP);
        ticks(2);
        check_state(NSL_STOPPED);
        check_val({6'h00, od, ip_o}, 8'h00);
        green_rises(3200, n);
        check_num(n, 3200 / (2 * BLINK_MS * TCK), 0);
        check_state(NSL_STOPPED);
        mgr_u.send_cmd(NSL_CMD_PREOP2);
        ticks(1);
        check_state(NSL_PRE_OP2);
        mgr_u.send_cmd(NSL_CMD_RESET);
        ticks(1);
        check_state(NSL_NOT_ACTIVE);
    endtask

    task automatic scen_switch;
        logic [7:0] tab [5] = '{8'h00, 8'h01, 8'hef, 8'hf0, 8'hff};
        logic ok;
        do_reset();
        for (int i = 0; i < 5; i++) begin
            set_sw(tab[i], 1'b0, 1'b0);
            ok = (tab[i] >= 8'h01 && tab[i] <= NODE_MAX);
            check_val(num, ok ? tab[i] : 8'h00);
            check_val({6'h00, nvalid, ninvalid}, {6'h00, ok, !ok});
        end
        set_sw(8'h00, 1'b1, 1'b0);
        check_val({6'h00, nvalid, ninvalid}, 8'h02);
        check_val(8'(red), 8'h01);
        set_sw(8'h00, 1'b1, 1'b1);
        check_val(8'(red), 8'h00);
        @(posedge mclk_i);
        cn_error_i <= 1'b1;
        ticks(3);
        check_val(8'(red), 8'h01);
        @(posedge mclk_i);
        cn_error_i <= 1'b0;
        hw_error_i <= 1'b1;
        @(posedge mclk_i);
        hw_error_i <= 1'b0;
        ticks(3);
        check_val(8'(stop), 8'h01);
    endtask

    task automatic scen_sys_stop;
        int k;
        int len;
        do_reset();
        set_sw(8'h01, 1'b0, 1'b0);
        mgr_u.set_mode(1'b0, 1'b0, 1'b0);
        mgr_u.send_frame(1'b0);
        @(posedge mclk_i);
        err_code_i  <= 4'h5;
        cfg_error_i <= 1'b1;
        @(posedge mclk_i);
        cfg_error_i <= 1'b0;
        len = 0;
        for (int i = 0; i < 5; i++) begin
            wait_red(1'b1, 9000, k);
            if (i > 0)
                len = len + k;
            if (i < 4) begin
                wait_red(1'b0, 3000, k);
                check_num(k, (err_code_i[i] ? ERR_LONG_MS : ERR_SHORT_MS)
                          * TCK, TCK);
                len = len + k;
            end
        end
        check_num(len, ERR_PERIOD_MS * TCK, TCK);
        check_val(8'(stop), 8'h01);
        flash_count(2);
    endtask

    initial begin
        rst_i          <= 1'b1;
        cfg_error_i    <= 1'b0;
        hw_error_i     <= 1'b0;
        cn_error_i     <= 1'b0;
        dna_mode_i     <= 1'b0;
        dna_assigned_i <= 1'b0;
        err_code_i     <= 4'h0;
        node_sw_hi_i   <= 4'h0;
        node_sw_lo_i   <= 4'h1;
        scen_wait_basic();
        scen_v1_path();
        scen_v2_path();
        scen_switch();
        scen_sys_stop();
        complete_run();
    end
endmodule

`default_nettype wire
